// >>> hdl/fhp_host_port.v
// Overview of operation
// - write data is taken at the rising edge of the write strobe
// - asynchronous reads latch the whole address at address strobe rise
// - burst start address latched at bus clock rise with strobe low
// - address inputs are ignored while the address strobe is high
// - reset pin restarts operation, ignored during power-up and boot load
// - chip select high deselects, idles and floats the data bus
// - data bus driven on reads only while output enable is low
// - array blocks hold exactly 64 pages
// - each array page is 1KB in two sectors
// - each main sector is 512B, 256 sixteen-bit words
// - two 16B spare sectors per page, 8 words each
// - spare words keep invalid-block marks and ECC bytes
// - 1KB boot buffer filled from the array, host readable at start
// - two independent 1KB data buffers, host and array work concurrently
// - each buffer sector is 512B main plus 16B spare, two sectors
// - interrupt output reports command completion, floats until enabled
// - ready output marks burst data, driven only with chip select low
`include "fhp_defs.vh"
`default_nettype none

module fhp_host_port (
    input wire mclk_i,
    input wire rst_n_i,
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire address_valid_strobe_n_i,
    input wire bus_clk_i,
    input wire hard_reset_n_i,
    input wire [`FHP_AW-1:0] address_bus_i,
    input wire [`FHP_DW-1:0] data_bus_i,
    output reg [`FHP_DW-1:0] data_bus_o,
    output wire data_bus_oe_n_o,
    output reg rdy_o,
    output wire rdy_oe_n_o,
    output wire int_o,
    output wire int_oe_n_o,
    input wire sync_read_mode_i,
    input wire irq_output_enable_bit_i,
    input wire cmd_done_i,
    input wire irq_clear_i,
    input wire boot_done_i,
    output reg boot_busy_o,
    output reg op_reset_o,
    output reg reg_wr_o,
    output reg [`FHP_AW-1:0] reg_addr_o,
    output reg [`FHP_DW-1:0] reg_wdata_o,
    input wire [`FHP_DW-1:0] reg_rdata_i,
    input wire core_we_i,
    input wire [`FHP_IDX_W-1:0] core_addr_i,
    input wire [`FHP_DW-1:0] core_wdata_i,
    output wire [`FHP_DW-1:0] core_rdata_o,
    input wire [`FHP_AW-1:0] core_page_i,
    output reg [`FHP_AW-1:0] core_block_o,
    output reg [`FHP_PAGE_BITS-1:0] core_page_in_block_o
);

    // ****************************************************************
    // organisation checks
    // ****************************************************************
    localparam PAGE_BYTES = `FHP_SECT_PER_PAGE * `FHP_SECT_BYTES;
    localparam PAGE_OK = (PAGE_BYTES == `FHP_BUF_BYTES) &&
        (`FHP_SECT_BYTES == 2 * `FHP_SECT_WORDS) &&
        (`FHP_SPARE_BYTES == 2 * `FHP_SPARE_WORDS) &&
        ((1 << `FHP_PAGE_BITS) == `FHP_PAGES_PER_BLOCK);

    // ****************************************************************
    // address decode
    // ****************************************************************
    // main words of all buffers first, then all spare words
    function [`FHP_IDX_W:0] fhp_decode;
        input [`FHP_AW-1:0] a;
        begin
            if (a < `FHP_MAIN_LIMIT) begin
                fhp_decode = {1'b1, a[`FHP_IDX_W-1:0]};
            end else if (a >= `FHP_SPARE_BASE && a < `FHP_SPARE_LIMIT) begin
                // spare words carry block marks and ECC
                fhp_decode = {1'b1, `FHP_SPARE_IDX +
                    {{(`FHP_IDX_W-`FHP_SPARE_OFS_W){1'b0}},
                     a[`FHP_SPARE_OFS_W-1:0]}};
            end else begin
                fhp_decode = {1'b0, {`FHP_IDX_W{1'b0}}};
            end
        end
    endfunction

    function fhp_is_reg;
        input [`FHP_AW-1:0] a;
        begin
            fhp_is_reg = (a >= `FHP_REG_BASE);
        end
    endfunction

    // ****************************************************************
    // pin sampling
    // ****************************************************************
    wire [`FHP_PIN_W-1:0] pins;
    reg [`FHP_PIN_W-1:0] s1_q;
    reg [`FHP_PIN_W-1:0] s2_q;
    reg [`FHP_PIN_W-1:0] s3_q;
    reg [`FHP_PIN_W-1:0] filt_q;
    reg [`FHP_PIN_W-1:0] prev_q;

    assign pins = {data_bus_i, address_bus_i, hard_reset_n_i, bus_clk_i,
        address_valid_strobe_n_i, we_n_i, oe_n_i, ce_n_i};

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= {`FHP_PIN_W{1'b1}};
            s2_q <= {`FHP_PIN_W{1'b1}};
            s3_q <= {`FHP_PIN_W{1'b1}};
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit moves only once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < `FHP_PIN_W; gi = gi + 1) begin : g_filt
            always @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    filt_q[gi] <= 1'b1;
                    prev_q[gi] <= 1'b1;
                end else begin
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                    prev_q[gi] <= filt_q[gi];
                end
            end
        end
    endgenerate

    wire ce_n = filt_q[`FHP_P_CE];
    wire oe_n = filt_q[`FHP_P_OE];
    wire we_n = filt_q[`FHP_P_WE];
    wire avd_n = filt_q[`FHP_P_AVD];
    wire pin_rst_n = filt_q[`FHP_P_RST];
    wire [`FHP_AW-1:0] addr = filt_q[`FHP_P_DATA-1:`FHP_P_ADDR];
    wire [`FHP_DW-1:0] wdata = filt_q[`FHP_PIN_W-1:`FHP_P_DATA];
    wire we_rise = we_n && !prev_q[`FHP_P_WE];
    wire clk_rise = filt_q[`FHP_P_CLK] && !prev_q[`FHP_P_CLK];

    // ****************************************************************
    // boot phase and reset pin
    // ****************************************************************
    wire op_rst = !boot_busy_o && !pin_rst_n;

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_busy_o <= 1'b1;
            op_reset_o <= 1'b0;
        end else begin
            // boot buffer is being filled; pin level is disregarded
            if (boot_done_i) begin
                boot_busy_o <= 1'b0;
            end
            op_reset_o <= op_rst;
        end
    end

    // ****************************************************************
    // address latching
    // ****************************************************************
    reg [`FHP_AW-1:0] lat_addr_q;
    reg [`FHP_AW-1:0] burst_addr_q;
    reg burst_act_q;
    reg fetch_q;
    reg prev_fetch_q;
    reg prev_fetch2_q;
    wire selected = !ce_n;

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lat_addr_q <= {`FHP_AW{1'b0}};
            burst_addr_q <= {`FHP_AW{1'b0}};
            burst_act_q <= 1'b0;
            fetch_q <= 1'b0;
        end else if (op_rst) begin
            lat_addr_q <= {`FHP_AW{1'b0}};
            burst_addr_q <= {`FHP_AW{1'b0}};
            burst_act_q <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= 1'b0;
            if (!selected) begin
                burst_act_q <= 1'b0;
            end else if (!sync_read_mode_i) begin
                burst_act_q <= 1'b0;
                // tracks while low: pins may move with the strobe
                if (!avd_n) begin
                    lat_addr_q <= addr;
                end
            end else if (clk_rise) begin
                if (!avd_n) begin
                    burst_addr_q <= addr;
                    burst_act_q <= 1'b1;
                end else if (burst_act_q && !oe_n) begin
                    fetch_q <= 1'b1;
                end
            end
            if (prev_fetch_q) begin
                burst_addr_q <= burst_addr_q + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // host writes
    // ****************************************************************
    // with the strobe high the address pins are not looked at
    wire [`FHP_AW-1:0] wr_addr = avd_n ? lat_addr_q : addr;
    wire [`FHP_IDX_W:0] wr_dec = fhp_decode(wr_addr);
    wire wr_take = we_rise && selected && !op_rst;
    wire mem_we = wr_take && wr_dec[`FHP_IDX_W];

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_wr_o <= 1'b0;
            reg_addr_o <= {`FHP_AW{1'b0}};
            reg_wdata_o <= {`FHP_DW{1'b0}};
        end else begin
            reg_wr_o <= wr_take && fhp_is_reg(wr_addr);
            if (wr_take) begin
                reg_addr_o <= wr_addr;
                reg_wdata_o <= wdata;
            end
        end
    end

    // ****************************************************************
    // buffer storage
    // ****************************************************************
    wire [`FHP_AW-1:0] rd_addr = sync_read_mode_i ? burst_addr_q :
        (avd_n ? lat_addr_q : addr);
    wire [`FHP_IDX_W:0] rd_dec = fhp_decode(rd_addr);
    wire [`FHP_DW-1:0] mem_rdata;
    reg rd_ok_q;
    reg rd_reg_q;

    // boot, data 0 and data 1 share one array; separate ports keep
    // host and array side independent
    fhp_buffer_mem u_mem (
        .mclk_i(mclk_i),
        .host_we_i(mem_we),
        .host_waddr_i(wr_dec[`FHP_IDX_W-1:0]),
        .host_wdata_i(wdata),
        .host_raddr_i(rd_dec[`FHP_IDX_W-1:0]),
        .host_rdata_o(mem_rdata),
        .core_we_i(core_we_i),
        .core_addr_i(core_addr_i),
        .core_wdata_i(core_wdata_i),
        .core_rdata_o(core_rdata_o)
    );

    // ****************************************************************
    // read data and ready
    // ****************************************************************
    wire [`FHP_DW-1:0] rd_word = rd_reg_q ? reg_rdata_i :
        (rd_ok_q ? mem_rdata : {`FHP_DW{1'b0}});

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ok_q <= 1'b0;
            rd_reg_q <= 1'b0;
            prev_fetch_q <= 1'b0;
            prev_fetch2_q <= 1'b0;
            data_bus_o <= {`FHP_DW{1'b0}};
            rdy_o <= 1'b0;
        end else begin
            rd_ok_q <= rd_dec[`FHP_IDX_W];
            rd_reg_q <= fhp_is_reg(rd_addr);
            prev_fetch_q <= prev_fetch2_q;
            prev_fetch2_q <= fetch_q;
            if (!selected || op_rst || !sync_read_mode_i) begin
                rdy_o <= 1'b0;
            end else if (fetch_q) begin
                rdy_o <= 1'b0;
            end else if (clk_rise && !avd_n) begin
                rdy_o <= 1'b0;
            end
            // word of the current address; the address advances after
            if (sync_read_mode_i) begin
                if (selected && burst_act_q && prev_fetch_q) begin
                    data_bus_o <= rd_word;
                    rdy_o <= 1'b1;
                end
            end else if (selected && !oe_n) begin
                data_bus_o <= rd_word;
            end
        end
    end

    // data bus floats unless selected and read-enabled; ready floats only when deselected
    assign data_bus_oe_n_o = ce_n || oe_n || !we_n;
    assign rdy_oe_n_o = ce_n;

    // ****************************************************************
    // completion interrupt
    // ****************************************************************
    reg irq_pend_q;
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_pend_q <= 1'b0;
        end else if (op_rst) begin
            irq_pend_q <= 1'b0;
        end else if (cmd_done_i) begin
            irq_pend_q <= 1'b1;
        end else if (irq_clear_i) begin
            irq_pend_q <= 1'b0;
        end
    end

    // floats from power-up until enabled, then ignores select/enable
    assign int_o = irq_pend_q;
    assign int_oe_n_o = !irq_output_enable_bit_i;

    // ****************************************************************
    // array page split
    // ****************************************************************
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_block_o <= {`FHP_AW{1'b0}};
            core_page_in_block_o <= {`FHP_PAGE_BITS{1'b0}};
        end else if (PAGE_OK) begin
            core_block_o <= core_page_i >> `FHP_PAGE_BITS;
            core_page_in_block_o <= core_page_i[`FHP_PAGE_BITS-1:0];
        end
    end

endmodule

`default_nettype wire

// >>> hdl/fhp_defs.vh
`ifndef FHP_DEFS_VH
`define FHP_DEFS_VH

// ****************************************************************
// widths
// ****************************************************************
`define FHP_AW 16
`define FHP_DW 16
`define FHP_IDX_W 11
`define FHP_SPARE_OFS_W 6
`define FHP_PAGE_BITS 6

// ****************************************************************
// array and buffer organisation
// ****************************************************************
`define FHP_PAGES_PER_BLOCK 64
`define FHP_SECT_PER_PAGE 2
`define FHP_SECT_BYTES 512
`define FHP_SECT_WORDS 256
`define FHP_SPARE_BYTES 16
`define FHP_SPARE_WORDS 8
`define FHP_BUF_COUNT 3
`define FHP_BUF_BYTES 1024
`define FHP_MAIN_WORDS (`FHP_BUF_COUNT*`FHP_SECT_PER_PAGE*`FHP_SECT_WORDS)
`define FHP_MEM_DEPTH (`FHP_MAIN_WORDS+`FHP_BUF_COUNT*`FHP_SECT_PER_PAGE*`FHP_SPARE_WORDS)

// ****************************************************************
// host address map, word addresses
// ****************************************************************
`define FHP_MAIN_LIMIT 16'h0600
`define FHP_SPARE_BASE 16'h8000
`define FHP_SPARE_LIMIT 16'h8030
`define FHP_SPARE_IDX 11'h600
`define FHP_REG_BASE 16'hF000

// ****************************************************************
// positions in the sampled pin vector
// ****************************************************************
`define FHP_P_CE 0
`define FHP_P_OE 1
`define FHP_P_WE 2
`define FHP_P_AVD 3
`define FHP_P_CLK 4
`define FHP_P_RST 5
`define FHP_P_ADDR 6
`define FHP_P_DATA 22
`define FHP_PIN_W 38

`endif

// >>> hdl/fhp_buffer_mem.v
`include "fhp_defs.vh"
`default_nettype none

module fhp_buffer_mem (
    input wire mclk_i,
    input wire host_we_i,
    input wire [`FHP_IDX_W-1:0] host_waddr_i,
    input wire [`FHP_DW-1:0] host_wdata_i,
    input wire [`FHP_IDX_W-1:0] host_raddr_i,
    output reg [`FHP_DW-1:0] host_rdata_o,
    input wire core_we_i,
    input wire [`FHP_IDX_W-1:0] core_addr_i,
    input wire [`FHP_DW-1:0] core_wdata_i,
    output reg [`FHP_DW-1:0] core_rdata_o
);

    reg [`FHP_DW-1:0] mem_q [0:`FHP_MEM_DEPTH-1];

    // two ports so the host can work one buffer while the array side
    // loads or programs another; a same-word clash goes to the host
    always @(posedge mclk_i) begin
        if (host_we_i) begin
            mem_q[host_waddr_i] <= host_wdata_i;
        end
        if (core_we_i && !(host_we_i && host_waddr_i == core_addr_i)) begin
            mem_q[core_addr_i] <= core_wdata_i;
        end
        host_rdata_o <= mem_q[host_raddr_i];
        core_rdata_o <= mem_q[core_addr_i];
    end

endmodule

`default_nettype wire

// >>> sim/fhp_hp_monitor.sv
`include "fhp_defs.vh"
`default_nettype none
module fhp_hp_monitor (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic irq_output_enable_bit_i,
    input wire logic cmd_done_i,
    input wire logic [`FHP_AW-1:0] core_page_i,
    input wire logic data_bus_oe_n_o,
    input wire logic rdy_o,
    input wire logic rdy_oe_n_o,
    input wire logic int_o,
    input wire logic int_oe_n_o,
    input wire logic boot_busy_o,
    input wire logic op_reset_o,
    input wire logic reg_wr_o,
    input wire logic [`FHP_AW-1:0] core_block_o,
    input wire logic [`FHP_PAGE_BITS-1:0] core_page_in_block_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ****************************************************************
    // pin filter is 3-4 cycles deep, so levels must settle for 6
    // ****************************************************************
    sequence s_desel;
        ce_n_i [*6];
    endsequence
    sequence s_rd;
        (!ce_n_i && !oe_n_i && we_n_i) [*6];
    endsequence
    property p_dq_float;
        s_desel |-> data_bus_oe_n_o;
    endproperty
    property p_oe_float;
        oe_n_i [*6] |-> data_bus_oe_n_o;
    endproperty
    property p_dq_drive;
        s_rd |-> !data_bus_oe_n_o;
    endproperty
    property p_rdy_float;
        s_desel |-> rdy_oe_n_o && !rdy_o;
    endproperty
    property p_no_wr_desel;
        s_desel |-> !reg_wr_o;
    endproperty
    property p_wr_pulse;
        reg_wr_o |=> !reg_wr_o;
    endproperty
    property p_boot_ignore;
        boot_busy_o |-> !op_reset_o;
    endproperty
    property p_int_float;
        !irq_output_enable_bit_i |-> int_oe_n_o;
    endproperty
    property p_int_set;
        cmd_done_i |-> ##[1:2] int_o;
    endproperty
    property p_split;
        1'b1 |=> core_block_o == ($past(core_page_i) >> 6) &&
            core_page_in_block_o == ($past(core_page_i) & 16'h003F);
    endproperty
    a_dq_float: assert property (p_dq_float)
        else $error("data bus driven while deselected");
    a_oe_float: assert property (p_oe_float)
        else $error("data bus driven with output enable high");
    a_dq_drive: assert property (p_dq_drive)
        else $error("data bus not driven during read");
    a_rdy_float: assert property (p_rdy_float)
        else $error("ready active while deselected");
    a_no_wr_desel: assert property (p_no_wr_desel)
        else $error("register write while deselected");
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("register write pulse too long");
    a_boot_ignore: assert property (p_boot_ignore)
        else $error("reset pin acted during boot load");
    a_int_float: assert property (p_int_float)
        else $error("interrupt pin driven while disabled");
    a_int_set: assert property (p_int_set)
        else $error("command completion not flagged");
    a_split: assert property (p_split)
        else $error("block and page split wrong");
endmodule
bind fhp_host_port fhp_hp_monitor u_mon (
    .mclk_i, .rst_n_i, .ce_n_i, .oe_n_i, .we_n_i,
    .irq_output_enable_bit_i, .cmd_done_i, .core_page_i,
    .data_bus_oe_n_o, .rdy_o, .rdy_oe_n_o, .int_o, .int_oe_n_o,
    .boot_busy_o, .op_reset_o, .reg_wr_o, .core_block_o,
    .core_page_in_block_o
);
`default_nettype wire

// >>> sim/fhp_host_model.sv
`default_nettype none
module fhp_host_model (
    input wire logic mclk_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_n_i,
    output var logic ce_n_o = 1'b1,
    output var logic oe_n_o = 1'b1,
    output var logic we_n_o = 1'b1,
    output var logic address_valid_strobe_n_o = 1'b1,
    output var logic bus_clk_o = 1'b0,
    output var logic [15:0] addr_o = 16'h0000,
    output var logic [15:0] data_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // host cycles; every level held past the device's pin filter
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic cs);
        @(posedge mclk_i);
        ce_n_o <= cs;
        address_valid_strobe_n_o <= 1'b0;
        addr_o <= a;
        data_o <= d;
        we_n_o <= 1'b0;
        step(4);
        we_n_o <= 1'b1;
        step(4);
        ce_n_o <= 1'b1;
        address_valid_strobe_n_o <= 1'b1;
        // released lines show the inverse, not a stale copy
        addr_o <= ~a;
        data_o <= ~d;
        step(6);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d,
                      output logic drv);
        @(posedge mclk_i);
        ce_n_o <= 1'b0;
        address_valid_strobe_n_o <= 1'b0;
        addr_o <= a;
        step(4);
        address_valid_strobe_n_o <= 1'b1;
        addr_o <= ~a;
        step(4);
        oe_n_o <= 1'b0;
        step(10);
        d = dq_i;
        drv = dq_oe_n_i;
        oe_n_o <= 1'b1;
        ce_n_o <= 1'b1;
        step(6);
    endtask
    // bus clock stands low between pulses
    task automatic bclk(input int hi);
        bus_clk_o <= 1'b1;
        step(hi);
        bus_clk_o <= 1'b0;
        step(hi);
    endtask
    task automatic burst_start(input logic [15:0] a);
        @(posedge mclk_i);
        ce_n_o <= 1'b0;
        address_valid_strobe_n_o <= 1'b0;
        addr_o <= a;
        step(4);
        bclk(4);
        address_valid_strobe_n_o <= 1'b1;
        addr_o <= ~a;
        oe_n_o <= 1'b0;
        step(4);
    endtask
    task automatic idle();
        oe_n_o <= 1'b1;
        ce_n_o <= 1'b1;
        step(8);
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_flash_host_port_buffers.sv
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    fails++; $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module tb_flash_host_port_buffers;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_n_i, oe_n_i, we_n_i, address_valid_strobe_n_i, bus_clk_i;
    logic [15:0] address_bus_i, hdata, data_bus_o, reg_addr_o, reg_wdata_o;
    logic [15:0] core_rdata_o, core_block_o;
    logic [15:0] core_page_i = 16'h0000;
    logic [15:0] core_wdata_i = 16'h0000;
    logic [10:0] core_addr_i = 11'h000;
    logic [5:0] core_page_in_block_o;
    logic hard_reset_n_i = 1'b1;
    logic irq_output_enable_bit_i = 1'b0;
    logic cmd_done_i = 1'b0;
    logic irq_clear_i = 1'b0;
    logic boot_done_i = 1'b0;
    logic core_we_i = 1'b0;
    logic sync_read_mode_i = 1'b0;
    logic [15:0] reg_rdata_i = 16'h0000;
    logic data_bus_oe_n_o, rdy_o, rdy_oe_n_o, int_o, int_oe_n_o;
    logic boot_busy_o, op_reset_o, reg_wr_o;
    wire logic [15:0] data_bus_i;
    int fails = 0;
    int num_checks = 0;
    assign data_bus_i = data_bus_oe_n_o ? hdata : data_bus_o;
    fhp_host_port DUT (
        .mclk_i, .rst_n_i, .ce_n_i, .oe_n_i, .we_n_i,
        .address_valid_strobe_n_i, .bus_clk_i, .hard_reset_n_i,
        .address_bus_i, .data_bus_i, .data_bus_o, .data_bus_oe_n_o,
        .rdy_o, .rdy_oe_n_o, .int_o, .int_oe_n_o,
        .sync_read_mode_i, .irq_output_enable_bit_i, .cmd_done_i,
        .irq_clear_i, .boot_done_i, .boot_busy_o, .op_reset_o, .reg_wr_o,
        .reg_addr_o, .reg_wdata_o, .reg_rdata_i, .core_we_i,
        .core_addr_i, .core_wdata_i, .core_rdata_o, .core_page_i,
        .core_block_o, .core_page_in_block_o
    );
    fhp_host_model HOST (
        .mclk_i, .dq_i(data_bus_o), .dq_oe_n_i(data_bus_oe_n_o),
        .ce_n_o(ce_n_i), .oe_n_o(oe_n_i), .we_n_o(we_n_i),
        .address_valid_strobe_n_o(address_valid_strobe_n_i),
        .bus_clk_o(bus_clk_i), .addr_o(address_bus_i), .data_o(hdata)
    );
    always #4 mclk_i = ~mclk_i;
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_boot();
        `CHK("boot busy", 1'b1, boot_busy_o)
        hard_reset_n_i <= 1'b0;
        HOST.step(8);
        `CHK("reset in boot", 1'b0, op_reset_o)
        hard_reset_n_i <= 1'b1;
        HOST.step(6);
        boot_done_i <= 1'b1;
        HOST.step(1);
        boot_done_i <= 1'b0;
        HOST.step(3);
        `CHK("boot idle", 1'b0, boot_busy_o)
        hard_reset_n_i <= 1'b0;
        HOST.step(8);
        `CHK("reset active", 1'b1, op_reset_o)
        hard_reset_n_i <= 1'b1;
        HOST.step(8);
        `CHK("reset gone", 1'b0, op_reset_o)
        $display("test boot done");
    endtask
    task automatic t_mem();
        logic [15:0] a[5] = '{16'h01FF, 16'h0200, 16'h0400,
                              16'h8010, 16'h802F};
        logic [15:0] d;
        logic drv;
        for (int i = 0; i < 5; i++) begin
            HOST.wr(a[i], a[i] ^ 16'h5A3C, 1'b0);
        end
        // deselected strobes must leave the word alone
        HOST.wr(16'h0200, 16'hFFFF, 1'b1);
        for (int i = 0; i < 5; i++) begin
            HOST.rd(a[i], d, drv);
            `CHK("word", a[i] ^ 16'h5A3C, d)
            `CHK("drive", 1'b0, drv)
        end
        HOST.rd(16'h1000, d, drv);
        `CHK("unmapped", 16'h0000, d)
        HOST.wr(16'hF000, 16'hBEEF, 1'b0);
        `CHK("reg addr", 16'hF000, reg_addr_o)
        `CHK("reg data", 16'hBEEF, reg_wdata_o)
        reg_rdata_i <= 16'hA55A;
        HOST.rd(16'hF002, d, drv);
        `CHK("reg read", 16'hA55A, d)
        $display("test mem done");
    endtask
    task automatic t_core();
        logic [15:0] d;
        logic drv;
        core_we_i <= 1'b1;
        core_addr_i <= 11'h300;
        core_wdata_i <= 16'hC0DE;
        core_page_i <= 16'h0083;
        HOST.step(1);
        core_we_i <= 1'b0;
        core_addr_i <= 11'h200;
        HOST.step(2);
        `CHK("core read", 16'h0200 ^ 16'h5A3C, core_rdata_o)
        `CHK("block", 16'h0002, core_block_o)
        `CHK("page", 6'h03, core_page_in_block_o)
        core_page_i <= 16'hFFFF;
        HOST.rd(16'h0300, d, drv);
        `CHK("host sees core", 16'hC0DE, d)
        `CHK("last block", 16'h03FF, core_block_o)
        `CHK("last page", 6'h3F, core_page_in_block_o)
        $display("test core done");
    endtask
    task automatic t_burst();
        sync_read_mode_i <= 1'b1;
        HOST.burst_start(16'h01FF);
        for (int i = 0; i < 2; i++) begin
            HOST.bclk(4);
            HOST.step(2);
            `CHK("burst word", 16'(16'h01FF + i) ^ 16'h5A3C, data_bus_o)
            `CHK("burst ready", 1'b1, rdy_o)
        end
        HOST.idle();
        `CHK("ready float", 1'b1, rdy_oe_n_o)
        `CHK("ready low", 1'b0, rdy_o)
        sync_read_mode_i <= 1'b0;
        $display("test burst done");
    endtask
    task automatic t_irq();
        `CHK("int float", 1'b1, int_oe_n_o)
        irq_output_enable_bit_i <= 1'b1;
        cmd_done_i <= 1'b1;
        HOST.step(1);
        cmd_done_i <= 1'b0;
        HOST.step(3);
        `CHK("int drive", 1'b0, int_oe_n_o)
        `CHK("int set", 1'b1, int_o)
        cmd_done_i <= 1'b1;
        irq_clear_i <= 1'b1;
        HOST.step(1);
        cmd_done_i <= 1'b0;
        irq_clear_i <= 1'b0;
        HOST.step(2);
        `CHK("set wins", 1'b1, int_o)
        irq_clear_i <= 1'b1;
        HOST.step(1);
        irq_clear_i <= 1'b0;
        HOST.step(3);
        `CHK("int clear", 1'b0, int_o)
        $display("test irq done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        HOST.step(20000);
        fails++;
        close_out();
    end
    initial begin
        HOST.step(20);
        rst_n_i <= 1'b1;
        HOST.step(4);
        t_boot();
        t_mem();
        t_core();
        t_burst();
        t_irq();
        close_out();
    end
endmodule
`default_nettype wire
